// ---- hdl/pag_pkg.sv ----
// access guard package: register map, field positions, parameter numbers, structs
// assumes a 32-bit ahb-lite slave port with one word per register
`default_nettype none
package pag_pkg;
  // register byte offsets
  localparam logic [7:0] PAG_OFF_WP      = 8'h00;
  localparam logic [7:0] PAG_OFF_VIEW    = 8'h04;
  localparam logic [7:0] PAG_OFF_G1_ENR  = 8'h08;
  localparam logic [7:0] PAG_OFF_G1_REM  = 8'h0C;
  localparam logic [7:0] PAG_OFF_G2_ENR  = 8'h10;
  localparam logic [7:0] PAG_OFF_G2_REM  = 8'h14;
  localparam logic [7:0] PAG_OFF_UDS     = 8'h18;
  localparam logic [7:0] PAG_OFF_STAT    = 8'h1C;
  localparam logic [7:0] PAG_OFF_UDV     = 8'h20;
  localparam logic [7:0] PAG_OFF_CMD     = 8'h24;
  localparam logic [15:0] PAG_REG_RESET  = 16'h0000;
  // status fields
  localparam int PAG_ST_GCNT_LSB  = 0;
  localparam int PAG_ST_UCNT_LSB  = 8;
  localparam int PAG_ST_GFULL     = 16;
  localparam int PAG_ST_UFULL     = 17;
  localparam int PAG_ST_UREFUSED  = 18;
  localparam int PAG_ST_CREFUSED  = 19;
  localparam int PAG_ST_BUSY      = 20;
  localparam int PAG_ST_LASTREJ   = 21;
  // command bits
  localparam int PAG_CMD_PCLR     = 0;
  localparam int PAG_CMD_ACLR     = 1;
  localparam int PAG_CMD_UCLR     = 2;
  // protection and view codes
  localparam logic [15:0] PAG_WP_STOP_PANEL = 16'h0000;
  localparam logic [15:0] PAG_WP_LOCK       = 16'h0001;
  localparam logic [15:0] PAG_WP_OPEN       = 16'h0002;
  localparam logic [15:0] PAG_VIEW_ALL      = 16'h0000;
  localparam logic [15:0] PAG_VIEW_G1       = 16'h0001;
  localparam logic [15:0] PAG_VIEW_G2       = 16'h000A;
  localparam logic [15:0] PAG_VIEW_BOTH     = 16'h000B;
  localparam logic [15:0] PAG_NUM_MAX       = 16'h03E7;
  localparam logic [15:0] PAG_NUM_ALL       = 16'h270F;
  // parameter numbers with special handling
  localparam logic [9:0] PAG_PRM_STALL     = 10'h016;
  localparam logic [9:0] PAG_PRM_TONE      = 10'h048;
  localparam logic [9:0] PAG_PRM_PANEL_DIS = 10'h04B;
  localparam logic [9:0] PAG_PRM_WP        = 10'h04D;
  localparam logic [9:0] PAG_PRM_OPMODE    = 10'h04F;
  localparam logic [9:0] PAG_PRM_IN_LO     = 10'h0B4;
  localparam logic [9:0] PAG_PRM_IN_HI     = 10'h0BB;
  localparam logic [9:0] PAG_PRM_RESET_TRM = 10'h0BC;
  localparam logic [9:0] PAG_PRM_START_TRM = 10'h0BD;
  localparam logic [9:0] PAG_PRM_OUT_LO    = 10'h0BE;
  localparam logic [9:0] PAG_PRM_OUT_HI    = 10'h0C3;
  // store clear kinds
  localparam logic [1:0] PAG_CLR_PARAM = 2'h0;
  localparam logic [1:0] PAG_CLR_ALL   = 2'h1;
  localparam logic [1:0] PAG_CLR_USER  = 2'h2;

  typedef enum logic [2:0] {
    PAG_UC_IDLE = 3'b001,
    PAG_UC_FACT = 3'b010,
    PAG_UC_LOAD = 3'b100
  } pag_uc_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       run_chg;
    logic [9:0] param;
    logic [15:0] data;
  } pag_pu_req_s;

  typedef struct packed {
    logic valid;
    logic granted;
    logic rejected;
  } pag_pu_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [9:0] param;
    logic [15:0] data;
  } pag_store_wr_s;

  typedef struct packed {
    logic       valid;
    logic [1:0] kind;
  } pag_store_clr_s;
endpackage
`default_nettype wire

// ---- hdl/pag_guard.sv ----
// parameter access guard: write protection, user groups and user initial values
// assumes one ahb-lite master, a panel port on clk_sys and pins needing sync
// Function
// - wp 0: write only stopped in panel mode
// - run-changeable writes while running; tone needs panel
// - wp 1: refuse writes and all clears
// - wp 1: five listed parameters stay writable
// - wp 2: write in any mode, running or not
// - wp 2: mode, input, start and output terminal parameters stop-only
// - at most 32 registrations across both groups
// - view 1, 10, 11 select group access
// - view 0 opens every parameter
// - enrol 0..999 adds number to group
// - remove 0..999 drops number from group
// - remove 9999 empties the whole group
// - up to 16 user initial values
// - select 9999 erases all user values
// - user clear loads stored user values
// - refuse user values for clear-excluded parameters
// - refuse writes while any start input on
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`default_nettype none
module pag_guard #(
  parameter int GRP_DEPTH = 32,
  parameter int UD_DEPTH  = 16
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire logic                    forward_start,
  input  wire logic                    reverse_start,
  input  wire logic                    motor_running,
  input  wire logic                    panel_mode,
  input  wire pag_pkg::pag_pu_req_s    pu_req,
  output logic                         pu_ready,
  output pag_pkg::pag_pu_rsp_s         pu_rsp,
  output logic [9:0]                   attr_param,
  input  wire logic                    attr_clear_excluded,
  output pag_pkg::pag_store_wr_s       store_wr,
  output pag_pkg::pag_store_clr_s      store_clr
);
  import pag_pkg::*;

  localparam int GI_W = $clog2(GRP_DEPTH);
  localparam int UI_W = $clog2(UD_DEPTH);

  // pin synchronisers
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {panel_mode, motor_running, reverse_start, forward_start};
      pin_sync_reg <= pin_meta_reg;
    end
  end
  wire start_on   = pin_sync_reg[0] | pin_sync_reg[1];
  wire running    = pin_sync_reg[2];
  wire panel_on   = pin_sync_reg[3];

  // bus slave: zero wait states, always okay
  logic       dp_wr_reg;
  logic [7:0] dp_addr_reg;
  wire addr_ph = hsel & htrans[1] & hready;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
    end else begin
      dp_wr_reg   <= addr_ph & hwrite;
      if (addr_ph) begin
        dp_addr_reg <= haddr[7:0];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire [15:0] wdat     = hwdata[15:0];
  wire        num_ok   = wdat <= PAG_NUM_MAX;
  wire        num_all  = wdat == PAG_NUM_ALL;
  wire wr_wp   = dp_wr_reg & (dp_addr_reg == PAG_OFF_WP);
  wire wr_view = dp_wr_reg & (dp_addr_reg == PAG_OFF_VIEW);
  wire wr_g1e  = dp_wr_reg & (dp_addr_reg == PAG_OFF_G1_ENR);
  wire wr_g1r  = dp_wr_reg & (dp_addr_reg == PAG_OFF_G1_REM);
  wire wr_g2e  = dp_wr_reg & (dp_addr_reg == PAG_OFF_G2_ENR);
  wire wr_g2r  = dp_wr_reg & (dp_addr_reg == PAG_OFF_G2_REM);
  wire wr_uds  = dp_wr_reg & (dp_addr_reg == PAG_OFF_UDS);
  wire wr_stat = dp_wr_reg & (dp_addr_reg == PAG_OFF_STAT);
  wire wr_udv  = dp_wr_reg & (dp_addr_reg == PAG_OFF_UDV);
  wire wr_cmd  = dp_wr_reg & (dp_addr_reg == PAG_OFF_CMD);

  logic [15:0] wp_reg, view_reg, g1e_reg, g1r_reg, g2e_reg, g2r_reg, uds_reg, udv_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg   <= PAG_REG_RESET;
      view_reg <= PAG_REG_RESET;
      g1e_reg  <= PAG_REG_RESET;
      g1r_reg  <= PAG_REG_RESET;
      g2e_reg  <= PAG_REG_RESET;
      g2r_reg  <= PAG_REG_RESET;
      uds_reg  <= PAG_REG_RESET;
      udv_reg  <= PAG_REG_RESET;
    end else begin
      if (wr_wp)   wp_reg   <= wdat;
      if (wr_view) view_reg <= wdat;
      if (wr_g1e)  g1e_reg  <= wdat;
      if (wr_g1r)  g1r_reg  <= wdat;
      if (wr_g2e)  g2e_reg  <= wdat;
      if (wr_g2r)  g2r_reg  <= wdat;
      if (wr_uds)  uds_reg  <= wdat;
      if (wr_udv)  udv_reg  <= wdat;
    end
  end

  function automatic logic [7:0] first_free(input logic [31:0] used, input int depth);
    logic [7:0] idx;
    idx = 8'hFF;
    for (int i = depth - 1; i >= 0; i--) begin
      if (!used[i]) idx = 8'(i);
    end
    return idx;
  endfunction

  function automatic logic [7:0] pop_count(input logic [31:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + 8'(v[i]);
    end
    return n;
  endfunction

  // group table
  logic [GRP_DEPTH-1:0] g_valid, g_two, g_bus_hit, g_req_hit, g_kill;
  wire        g_enr     = (wr_g1e | wr_g2e) & num_ok;
  wire        g_enr_two = wr_g2e;
  wire        g_rem     = wr_g1r | wr_g2r;
  wire        g_rem_two = wr_g2r;
  wire        g_dup     = |(g_bus_hit & (g_enr_two ? g_two : ~g_two));
  wire [7:0]  g_free    = first_free(32'(g_valid), GRP_DEPTH);
  wire        g_room    = g_free != 8'hFF;
  wire        g_fill    = g_enr & ~g_dup & g_room;
  wire        g_over    = g_enr & ~g_dup & ~g_room;

  genvar gi;
  generate
    for (gi = 0; gi < GRP_DEPTH; gi++) begin : g_entry
      logic       valid_reg;
      logic       two_reg;
      logic [9:0] param_reg;
      assign g_valid[gi]   = valid_reg;
      assign g_two[gi]     = two_reg;
      assign g_bus_hit[gi] = valid_reg & (param_reg == wdat[9:0]);
      assign g_req_hit[gi] = valid_reg & (param_reg == pu_req.param);
      assign g_kill[gi]    = g_rem & (two_reg == g_rem_two) &
                             (num_all | (num_ok & g_bus_hit[gi]));
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          valid_reg <= 1'b0;
          two_reg   <= 1'b0;
          param_reg <= 10'h000;
        end else if (g_kill[gi]) begin
          valid_reg <= 1'b0;
        end else if (g_fill && g_free == 8'(gi)) begin
          valid_reg <= 1'b1;
          two_reg   <= g_enr_two;
          param_reg <= wdat[9:0];
        end
      end
    end
  endgenerate

  // user initial value table
  logic [UD_DEPTH-1:0] u_valid, u_bus_hit;
  logic [9:0]  u_param [UD_DEPTH];
  logic [15:0] u_value [UD_DEPTH];
  assign attr_param = wdat[9:0];
  wire        u_sel     = wr_uds & num_ok;
  wire        u_refuse  = u_sel & attr_clear_excluded;
  wire        u_hit     = |u_bus_hit;
  wire [7:0]  u_free    = first_free(32'(u_valid), UD_DEPTH);
  wire        u_room    = u_free != 8'hFF;
  wire        u_ok      = u_sel & ~attr_clear_excluded & (u_hit | u_room);
  wire        u_over    = u_sel & ~attr_clear_excluded & ~u_hit & ~u_room;
  wire        u_wipe    = wr_uds & num_all;

  genvar ui;
  generate
    for (ui = 0; ui < UD_DEPTH; ui++) begin : u_entry
      logic        valid_reg;
      logic [9:0]  param_reg;
      logic [15:0] value_reg;
      assign u_valid[ui]   = valid_reg;
      assign u_param[ui]   = param_reg;
      assign u_value[ui]   = value_reg;
      assign u_bus_hit[ui] = valid_reg & (param_reg == wdat[9:0]);
      wire set = u_ok & (u_hit ? u_bus_hit[ui] : (u_free == 8'(ui)));
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          valid_reg <= 1'b0;
          param_reg <= 10'h000;
          value_reg <= 16'h0000;
        end else if (u_wipe) begin
          valid_reg <= 1'b0;
        end else if (set) begin
          valid_reg <= 1'b1;
          param_reg <= wdat[9:0];
          value_reg <= udv_reg;
        end
      end
    end
  endgenerate

  // clear commands and user clear sequencer
  pag_uc_state_e uc_state_reg, uc_state_next;
  logic [UI_W-1:0] uc_idx_reg;
  wire uc_idle   = uc_state_reg == PAG_UC_IDLE;
  wire clr_any   = wr_cmd & (|wdat[2:0]);
  wire clr_lock  = wp_reg == PAG_WP_LOCK;
  wire clr_go    = clr_any & uc_idle & ~clr_lock;
  wire clr_ref   = clr_any & clr_lock;
  wire uclr_go   = clr_go & wdat[PAG_CMD_UCLR];
  wire uc_last   = uc_idx_reg == UI_W'(UD_DEPTH - 1);
  wire [1:0] clr_kind = wdat[PAG_CMD_UCLR] ? PAG_CLR_USER :
                        wdat[PAG_CMD_ACLR] ? PAG_CLR_ALL : PAG_CLR_PARAM;

  always_comb begin
    uc_state_next = uc_state_reg;
    case (uc_state_reg)
      PAG_UC_IDLE: if (uclr_go) uc_state_next = PAG_UC_FACT;
      PAG_UC_FACT: uc_state_next = PAG_UC_LOAD;
      PAG_UC_LOAD: if (uc_last) uc_state_next = PAG_UC_IDLE;
      default:     uc_state_next = PAG_UC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      uc_state_reg <= PAG_UC_IDLE;
      uc_idx_reg   <= '0;
    end else begin
      uc_state_reg <= uc_state_next;
      uc_idx_reg   <= (uc_state_reg == PAG_UC_LOAD) ? uc_idx_reg + 1'b1 : '0;
    end
  end

  // access decision for panel requests
  assign pu_ready = uc_idle;
  wire req_take = pu_req.valid & pu_ready;
  wire in_g1    = |(g_req_hit & ~g_two);
  wire in_g2    = |(g_req_hit & g_two);
  wire view_ok  = (view_reg == PAG_VIEW_G1)   ? in_g1 :
                  (view_reg == PAG_VIEW_G2)   ? in_g2 :
                  (view_reg == PAG_VIEW_BOTH) ? (in_g1 | in_g2) : 1'b1;
  wire [9:0] rp = pu_req.param;
  wire lock_exc = (rp == PAG_PRM_STALL) | (rp == PAG_PRM_PANEL_DIS) | (rp == PAG_PRM_WP) |
                  (rp == PAG_PRM_OPMODE) | (rp == PAG_PRM_RESET_TRM);
  wire stop_only = (rp == PAG_PRM_OPMODE) | (rp == PAG_PRM_START_TRM) |
                   ((rp >= PAG_PRM_IN_LO) & (rp <= PAG_PRM_IN_HI)) |
                   ((rp >= PAG_PRM_OUT_LO) & (rp <= PAG_PRM_OUT_HI));
  wire wp0_ok = (panel_on & ~running) |
                (pu_req.run_chg & ((rp != PAG_PRM_TONE) | panel_on));
  wire wp2_ok = ~(stop_only & running);
  wire wp_ok  = (wp_reg == PAG_WP_STOP_PANEL) ? wp0_ok :
                (wp_reg == PAG_WP_LOCK)       ? lock_exc :
                (wp_reg == PAG_WP_OPEN)       ? wp2_ok : 1'b0;
  wire grant  = view_ok & (~pu_req.write | (wp_ok & ~start_on));

  pag_pu_rsp_s    rsp_reg;
  pag_store_wr_s  swr_reg;
  pag_store_clr_s sclr_reg;
  logic           lastrej_reg;
  wire            uc_load = (uc_state_reg == PAG_UC_LOAD) & u_valid[uc_idx_reg];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsp_reg     <= '0;
      swr_reg     <= '0;
      sclr_reg    <= '0;
      lastrej_reg <= 1'b0;
    end else begin
      rsp_reg.valid    <= req_take;
      rsp_reg.granted  <= req_take & grant;
      rsp_reg.rejected <= req_take & ~grant;
      if (req_take) lastrej_reg <= ~grant;
      // refused writes never reach the store
      swr_reg.valid    <= uc_load | (req_take & pu_req.write & grant);
      swr_reg.param    <= uc_load ? u_param[uc_idx_reg] : pu_req.param;
      swr_reg.data     <= uc_load ? u_value[uc_idx_reg] : pu_req.data;
      sclr_reg.valid   <= clr_go;
      sclr_reg.kind    <= clr_kind;
    end
  end
  assign pu_rsp    = rsp_reg;
  assign store_wr  = swr_reg;
  assign store_clr = sclr_reg;

  // sticky status, set wins over write-one-to-clear
  logic [3:0] sticky_reg;
  wire  [3:0] sticky_set = {clr_ref, u_refuse, u_over, g_over};
  wire  [3:0] sticky_clr = wr_stat ? hwdata[PAG_ST_CREFUSED:PAG_ST_GFULL] : 4'h0;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sticky_reg <= 4'h0;
    end else begin
      sticky_reg <= (sticky_reg & ~sticky_clr) | sticky_set;
    end
  end

  wire [7:0] g_cnt = pop_count(32'(g_valid));
  wire [7:0] u_cnt = pop_count(32'(u_valid));
  wire [31:0] stat_word = {10'h000, lastrej_reg, ~uc_idle, sticky_reg, u_cnt, g_cnt};

  // read mux over the data-phase address; unmapped reads return zero
  logic [31:0] rd_word;
  always_comb begin
    if (dp_addr_reg == PAG_OFF_WP)          rd_word = {16'h0000, wp_reg};
    else if (dp_addr_reg == PAG_OFF_VIEW)   rd_word = {16'h0000, view_reg};
    else if (dp_addr_reg == PAG_OFF_G1_ENR) rd_word = {16'h0000, g1e_reg};
    else if (dp_addr_reg == PAG_OFF_G1_REM) rd_word = {16'h0000, g1r_reg};
    else if (dp_addr_reg == PAG_OFF_G2_ENR) rd_word = {16'h0000, g2e_reg};
    else if (dp_addr_reg == PAG_OFF_G2_REM) rd_word = {16'h0000, g2r_reg};
    else if (dp_addr_reg == PAG_OFF_UDS)    rd_word = {16'h0000, uds_reg};
    else if (dp_addr_reg == PAG_OFF_STAT)   rd_word = stat_word;
    else if (dp_addr_reg == PAG_OFF_UDV)    rd_word = {16'h0000, udv_reg};
    else                                    rd_word = 32'h0000_0000;
  end
  assign hrdata = rd_word;

  // hsize is not checked: only whole-word transfers are expected
  wire unused_ok = &{1'b0, hsize, hwdata[31:16], haddr[31:8], GI_W[0]};
endmodule
`default_nettype wire

// ---- tb/pag_guard_monitor.sv ----
// checker: panel port relations of the access guard
// assumes a bind onto pag_guard; pins delayed two stages as in the guard
`default_nettype none
module pag_guard_monitor import pag_pkg::*; #(
  parameter int GRP_DEPTH = 32,
  parameter int UD_DEPTH  = 16
) (
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic                 forward_start,
  input wire logic                 reverse_start,
  input wire logic                 motor_running,
  input wire logic                 panel_mode,
  input wire pag_pkg::pag_pu_req_s pu_req,
  input wire logic                 pu_ready,
  input wire pag_pkg::pag_pu_rsp_s pu_rsp,
  input wire pag_pkg::pag_store_wr_s  store_wr,
  input wire pag_pkg::pag_store_clr_s store_clr
);
  logic [1:0]  fs_q, rs_q, mr_q, pm_q;
  logic        aw_q;
  logic [7:0]  aa_q;
  logic [15:0] wp_q;
  // shadow of the protection setting, taken from bus writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {fs_q, rs_q, mr_q, pm_q} <= 8'h00;
      aw_q <= 1'b0;
      aa_q <= 8'h00;
      wp_q <= 16'h0000;
    end else begin
      {fs_q, rs_q, mr_q, pm_q} <= {fs_q[0], forward_start, rs_q[0], reverse_start,
                                   mr_q[0], motor_running, pm_q[0], panel_mode};
      aw_q <= hsel && htrans[1] && hready && hwrite;
      aa_q <= haddr[7:0];
      if (aw_q && aa_q == PAG_OFF_WP) wp_q <= hwdata[15:0];
    end
  end
  wire take  = pu_req.valid && pu_ready;
  wire wtake = take && pu_req.write;
  wire lock_ok = pu_req.param inside {PAG_PRM_STALL, PAG_PRM_PANEL_DIS, PAG_PRM_WP, PAG_PRM_OPMODE,
                                      PAG_PRM_RESET_TRM};
  wire stop_only = pu_req.param inside {PAG_PRM_OPMODE, PAG_PRM_START_TRM, [PAG_PRM_IN_LO:PAG_PRM_IN_HI],
                                        [PAG_PRM_OUT_LO:PAG_PRM_OUT_HI]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wtake;
    wtake;
  endsequence
  sequence s_granted;
    pu_rsp.granted;
  endsequence
  a_rsp_after_take: assert property (take |=> pu_rsp.valid && (pu_rsp.granted != pu_rsp.rejected))
    else $error("panel request not answered once");
  a_rsp_needs_take: assert property (pu_rsp.valid |-> $past(take))
    else $error("answer without request");
  a_refused_no_store: assert property (pu_rsp.rejected |-> !store_wr.valid)
    else $error("store written on refusal");
  a_grant_stores: assert property (s_wtake ##1 s_granted |-> store_wr.valid && store_wr.param == $past(pu_req.param)
                                   && store_wr.data == $past(pu_req.data))
    else $error("granted write not stored");
  a_start_refuse: assert property (wtake && (fs_q[1] || rs_q[1]) |=> pu_rsp.rejected)
    else $error("write taken with start input on");
  a_wp0_refuse: assert property (wtake && wp_q == PAG_WP_STOP_PANEL && !(pm_q[1] && !mr_q[1]) &&
                                 (!pu_req.run_chg || (pu_req.param == PAG_PRM_TONE && !pm_q[1]))
                                 |=> pu_rsp.rejected)
    else $error("write outside stopped panel mode");
  a_lock_refuse: assert property (wtake && wp_q == PAG_WP_LOCK && !lock_ok |=> pu_rsp.rejected)
    else $error("write taken while locked");
  a_wp2_stop_only: assert property (wtake && wp_q == PAG_WP_OPEN && mr_q[1] && stop_only
                                    |=> pu_rsp.rejected)
    else $error("stop-only parameter written while running");
  a_uclr_hold_ready: assert property (store_clr.valid && store_clr.kind == PAG_CLR_USER
                                      |-> (!pu_ready) [*8])
    else $error("panel accepted during user clear");
endmodule
`default_nettype wire

// ---- tb/pag_store_model.sv ----
// parameter store model: attribute lookup and a log of writes and clears
// assumes the guard's store ports on the same clock
`default_nettype none
module pag_store_model import pag_pkg::*; #(
  parameter logic [9:0] EXCL_PARAM = 10'h009
) (
  input  wire logic                   clk_sys,
  input  wire logic [9:0]             attr_param,
  output logic                        attr_clear_excluded,
  input  wire pag_pkg::pag_store_wr_s  store_wr,
  input  wire pag_pkg::pag_store_clr_s store_clr
);
  int            n_clr = 0;
  pag_store_wr_s last_wr = '0;
  logic [1:0]    last_kind = 2'h3;
  // one excluded number is enough to steer the refusal path
  assign attr_clear_excluded = (attr_param == EXCL_PARAM);
  always @(posedge clk_sys) begin
    if (store_wr.valid) last_wr <= store_wr;
    if (store_clr.valid) begin
      n_clr <= n_clr + 1;
      last_kind <= store_clr.kind;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pag_guard_tb_top.sv ----
// testbench: access guard driven over ahb-lite, panel port and pins
// assumes the store model answers attributes and logs store traffic
`default_nettype none
module pag_guard_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pag_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic hreadyout, hresp, pu_ready, excl;
  logic forward_start = 1'b0, reverse_start = 1'b0, motor_running = 1'b0, panel_mode = 1'b0;
  logic [9:0]  attr_param;
  pag_pu_req_s pu_req = '0;
  pag_pu_rsp_s pu_rsp;
  pag_store_wr_s store_wr;
  pag_store_clr_s store_clr;
  int n_errors = 0, compares = 0;
  pag_guard i_pag_guard (.clk_sys, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .forward_start, .reverse_start, .motor_running,
    .panel_mode, .pu_req, .pu_ready, .pu_rsp, .attr_param, .attr_clear_excluded(excl), .store_wr, .store_clr);
  pag_store_model i_pag_store_model (.clk_sys, .attr_param, .attr_clear_excluded(excl), .store_wr, .store_clr);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= {16'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input string msg);
    logic [31:0] r;
    bus(1'b0, a, 16'h0, r);
    check((r & m) === e && hresp === 1'b0, msg);
  endtask
  task automatic pins(input logic run, input logic pnl, input logic fs, input logic rs);
    @(posedge clk_sys);
    {motor_running, panel_mode, forward_start, reverse_start} <= {run, pnl, fs, rs};
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic pu(input logic w, input logic rc, input logic [9:0] p, input logic g, input string msg);
    @(posedge clk_sys);
    pu_req <= {1'b1, w, rc, p, 16'h5A5A};
    do @(posedge clk_sys); while (pu_ready !== 1'b1);
    pu_req.valid <= 1'b0;
    @(negedge clk_sys);
    check(pu_rsp === {1'b1, g, !g}, msg);
    check(store_wr.valid === (w && g), msg);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 11; i++) rd(8'(4 * i), '1, 32'h0, "reset value");
  endtask
  task automatic t_wp0;
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    pu(1'b1, 1'b0, 10'h064, 1'b1, "stopped panel write");
    pins(1'b1, 1'b1, 1'b0, 1'b0);
    pu(1'b1, 1'b0, 10'h064, 1'b0, "running write");
    pu(1'b1, 1'b1, 10'h064, 1'b1, "run changeable write");
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pu(1'b1, 1'b1, PAG_PRM_TONE, 1'b0, "tone outside panel");
    pins(1'b0, 1'b1, 1'b1, 1'b0);
    pu(1'b1, 1'b0, 10'h064, 1'b0, "forward start on");
    pins(1'b0, 1'b1, 1'b0, 1'b1);
    pu(1'b1, 1'b0, 10'h064, 1'b0, "reverse start on");
  endtask
  task automatic t_wp1;
    logic [9:0] ex [5] = '{PAG_PRM_STALL, PAG_PRM_PANEL_DIS, PAG_PRM_WP, PAG_PRM_OPMODE, PAG_PRM_RESET_TRM};
    int c;
    wr(PAG_OFF_WP, PAG_WP_LOCK);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    pu(1'b1, 1'b1, 10'h064, 1'b0, "locked write");
    for (int i = 0; i < 5; i++) pu(1'b1, 1'b0, ex[i], 1'b1, "locked exception");
    c = i_pag_store_model.n_clr;
    wr(PAG_OFF_CMD, 16'h0002);
    rd(PAG_OFF_STAT, 32'h00080000, 32'h00080000, "clear refused flag");
    check(i_pag_store_model.n_clr == c, "clear while locked");
  endtask
  task automatic t_wp2;
    logic [9:0] so [6] = '{PAG_PRM_OPMODE, PAG_PRM_IN_LO, PAG_PRM_IN_HI, PAG_PRM_START_TRM, PAG_PRM_OUT_LO,
                           PAG_PRM_OUT_HI};
    wr(PAG_OFF_WP, PAG_WP_OPEN);
    pu(1'b1, 1'b0, 10'h064, 1'b1, "open running write");
    for (int i = 0; i < 6; i++) pu(1'b1, 1'b0, so[i], 1'b0, "stop-only running");
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    pu(1'b1, 1'b0, PAG_PRM_IN_LO, 1'b1, "stop-only stopped");
    wr(PAG_OFF_CMD, 16'h0001);
    wr(PAG_OFF_WP, PAG_WP_STOP_PANEL);
    check(i_pag_store_model.last_kind === PAG_CLR_PARAM, "param clear kind");
    pins(1'b0, 1'b1, 1'b0, 1'b0);
  endtask
  task automatic t_groups;
    wr(PAG_OFF_G1_ENR, 16'h0005);
    wr(PAG_OFF_G2_ENR, 16'h0007);
    wr(PAG_OFF_VIEW, PAG_VIEW_G1);
    pu(1'b0, 1'b0, 10'h005, 1'b1, "group one read");
    pu(1'b1, 1'b0, 10'h007, 1'b0, "group one miss");
    wr(PAG_OFF_VIEW, PAG_VIEW_G2);
    pu(1'b1, 1'b0, 10'h007, 1'b1, "group two write");
    pu(1'b0, 1'b0, 10'h005, 1'b0, "group two miss");
    wr(PAG_OFF_VIEW, PAG_VIEW_BOTH);
    pu(1'b0, 1'b0, 10'h005, 1'b1, "union read");
    pu(1'b0, 1'b0, 10'h006, 1'b0, "union miss");
    wr(PAG_OFF_G1_REM, 16'h0005);
    pu(1'b1, 1'b0, 10'h005, 1'b0, "removed entry");
    for (int i = 0; i < 31; i++) wr(PAG_OFF_G2_ENR, 16'h00C8 + 16'(i));
    rd(PAG_OFF_STAT, 32'h000100FF, 32'h00000020, "32 registrations");
    wr(PAG_OFF_G2_ENR, 16'h012C);
    rd(PAG_OFF_STAT, 32'h000100FF, 32'h00010020, "registration overflow");
    wr(PAG_OFF_G2_REM, PAG_NUM_ALL);
    rd(PAG_OFF_STAT, 32'h000000FF, 32'h0, "group wiped");
    wr(PAG_OFF_VIEW, PAG_VIEW_ALL);
    pu(1'b1, 1'b0, 10'h006, 1'b1, "filter off");
  endtask
  task automatic t_udef;
    wr(PAG_OFF_UDV, 16'h1234);
    wr(PAG_OFF_UDS, 16'h0009);
    rd(PAG_OFF_STAT, 32'h0004FF00, 32'h00040000, "excluded value refused");
    for (int i = 0; i < 16; i++) wr(PAG_OFF_UDS, 16'h0190 + 16'(i));
    rd(PAG_OFF_STAT, 32'h0002FF00, 32'h00001000, "16 user values");
    wr(PAG_OFF_UDS, 16'h01F4);
    rd(PAG_OFF_STAT, 32'h0002FF00, 32'h00021000, "user table overflow");
    wr(PAG_OFF_UDS, PAG_NUM_ALL);
    rd(PAG_OFF_STAT, 32'h0000FF00, 32'h0, "user values erased");
    wr(PAG_OFF_UDS, 16'h0007);
    wr(PAG_OFF_CMD, 16'h0004);
    repeat (20) @(posedge clk_sys);
    check(i_pag_store_model.last_kind === PAG_CLR_USER, "user clear kind");
    check(i_pag_store_model.last_wr === {1'b1, 10'h007, 16'h1234}, "user value applied");
  endtask
  task automatic print_verdict;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_wp0();
    t_wp1();
    t_wp2();
    t_groups();
    t_udef();
    print_verdict();
  end
  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    $display("ERROR %0t run timed out", $time);
    print_verdict();
  end
endmodule
bind pag_guard pag_guard_monitor #(.GRP_DEPTH(GRP_DEPTH), .UD_DEPTH(UD_DEPTH)) i_pag_guard_monitor (.clk_sys,
  .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .forward_start, .reverse_start, .motor_running,
  .panel_mode, .pu_req, .pu_ready, .pu_rsp, .store_wr, .store_clr);
`default_nettype wire
